/* File: rdso_pkg.sv */
// Purpose: Shared constants and types for the redriver standby and output control block
// Assumes: pclk at 200 MHz; four-level pins arrive as a two-bit level code
// Notes:   Register offsets are byte addresses on a 32-bit APB bus
package rdso_pkg;
    localparam int          CLK_MHZ        = 200;
    localparam int          ACT_LOSS_NS    = 1000;
    localparam int          ACT_LOSS_CYC   = ACT_LOSS_NS * CLK_MHZ / 1000;
    localparam int          FREQ_WIN_NS    = 5120;
    localparam int          FREQ_WIN_CYC   = FREQ_WIN_NS * CLK_MHZ / 1000;
    localparam int          F_OPEN_EDGES   = 20;
    localparam int          F_300_EDGES    = 24;
    localparam int          STRAP_SETTLE   = 3;

    localparam logic [7:0]  OFF_CTRL       = 8'h00;
    localparam logic [7:0]  OFF_SLEW       = 8'h04;
    localparam logic [7:0]  OFF_STAT       = 8'h08;

    localparam int          CTRL_PD        = 0;
    localparam int          CTRL_SBY_DIS   = 1;
    localparam int          CTRL_AC        = 2;
    localparam int          CTRL_AUTO14    = 3;
    localparam int          CTRL_TERM_LSB  = 4;
    localparam int          CTRL_LIMITED   = 6;
    localparam int          CTRL_SWAP      = 7;
    localparam int          CTRL_EMPH_LSB  = 8;
    localparam int          CTRL_W         = 10;
    localparam logic [9:0]  CTRL_RST       = 10'h001;

    localparam int          SLEW_CLK_LSB   = 0;
    localparam int          SLEW_LOW_LSB   = 3;
    localparam int          SLEW_MID_LSB   = 6;
    localparam int          SLEW_HIGH_LSB  = 9;
    localparam int          SLEW_W         = 12;
    localparam logic [11:0] SLEW_RST       = 12'h000;

    typedef enum logic [1:0] {LVL_0, LVL_R, LVL_F, LVL_1} rdso_lvl_t;
    typedef enum logic [1:0] {MODE_14, MODE_20, MODE_21} rdso_mode_t;
    typedef enum logic [1:0] {RATE_3G, RATE_6G, RATE_HI} rdso_rate_t;
    typedef enum logic [2:0] {TERM_OPEN, TERM_P300, TERM_P100, TERM_S150, TERM_S50} rdso_term_t;
    typedef enum logic [2:0] {
        EMPH_PRE35, EMPH_DE25, EMPH_ZERO, EMPH_PRE60,
        EMPH_FFE0, EMPH_FFE1, EMPH_FFE2, EMPH_FFE3
    } rdso_emph_t;
    typedef enum logic [1:0] {ST_OFF, ST_STANDBY, ST_ACTIVE} rdso_state_t;
endpackage

/* File: rdso_lane_if.sv */
// Purpose: Carries one sampled lane level to its activity detector and the results back
// Assumes: lane_lvl is already synchronised to pclk
// Notes:   edge_cnt holds rising edges seen in the last measuring window
`timescale 1ns/1ps
`default_nettype none
interface rdso_lane_if;
    logic        lane_lvl;
    logic        active;
    logic [15:0] edge_cnt;
    modport det (input lane_lvl, output active, output edge_cnt);
    modport ctl (output lane_lvl, input active, input edge_cnt);
endinterface
`default_nettype wire

/* File: rdso_act_det.sv */
// Purpose: Lane activity detector and edge counter for one input lane
// Assumes: Lane level sampled by pclk, far below pclk in toggle rate
// Notes:   Activity drops after LOSS_CYC cycles without a rising edge
`timescale 1ns/1ps
`default_nettype none
module rdso_act_det #(
    parameter int LOSS_CYC = rdso_pkg::ACT_LOSS_CYC,
    parameter int WIN_CYC  = rdso_pkg::FREQ_WIN_CYC
) (
    input  wire logic pclk,
    input  wire logic presetn,
    rdso_lane_if.det  lane
);
    import rdso_pkg::*;

    logic        prev_q, prev_d;
    logic [15:0] idle_q, idle_d;
    logic        act_q, act_d;
    logic [15:0] win_q, win_d;
    logic [15:0] cnt_q, cnt_d;
    logic [15:0] edges_q, edges_d;
    logic        rise;

    always_comb begin
        rise    = lane.lane_lvl & ~prev_q;
        prev_d  = lane.lane_lvl;
        idle_d  = idle_q;
        act_d   = act_q;
        win_d   = win_q + 16'h1;
        cnt_d   = cnt_q + {15'h0, rise};
        edges_d = edges_q;
        if (rise) begin
            idle_d = 16'h0;
            act_d  = 1'b1;
        end else if (idle_q == 16'(LOSS_CYC - 1)) begin
            act_d = 1'b0;
        end else begin
            idle_d = idle_q + 16'h1;
        end
        if (win_q == 16'(WIN_CYC - 1)) begin
            win_d   = 16'h0;
            cnt_d   = 16'h0;
            edges_d = cnt_q + {15'h0, rise};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_q  <= 1'b0;
            idle_q  <= 16'h0;
            act_q   <= 1'b0;
            win_q   <= 16'h0;
            cnt_q   <= 16'h0;
            edges_q <= 16'h0;
        end else begin
            prev_q  <= prev_d;
            idle_q  <= idle_d;
            act_q   <= act_d;
            win_q   <= win_d;
            cnt_q   <= cnt_d;
            edges_q <= edges_d;
        end
    end

    assign lane.active   = act_q;
    assign lane.edge_cnt = edges_q;
endmodule
`default_nettype wire

/* File: rdso_ctrl.sv */
// Purpose: Standby state machine, detect indicator and transmitter setting decode
// Assumes: hdmi_mode, frl_rate and txffe_level come from snoop logic on pclk
// Notes:   Strap pins and lane levels are asynchronous and pass two flip-flops
//
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module rdso_ctrl #(
    parameter int LOSS_CYC = rdso_pkg::ACT_LOSS_CYC,
    parameter int WIN_CYC  = rdso_pkg::FREQ_WIN_CYC
) (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    output logic [31:0]              prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic [1:0]          cfg_mode_pin,
    input  wire logic                power_down_pin,
    input  wire logic                coupling_select_pin,
    input  wire logic                config_zero_pin,
    input  wire logic                lane_swap_pin,
    input  wire logic [1:0]          emphasis_select_pin,
    input  wire logic [1:0]          linear_select_pin,
    input  wire logic                in_clock_lane,
    input  wire logic                input_data_lane_two,
    input  wire rdso_pkg::rdso_mode_t hdmi_mode,
    input  wire rdso_pkg::rdso_rate_t frl_rate,
    input  wire logic [1:0]          txffe_level,
    output logic                     signal_detect_indicator_o,
    output logic                     signal_detect_indicator_oe,
    output logic [3:0]               lane_out_en,
    output logic                     tx_internal_bias,
    output rdso_pkg::rdso_term_t     tx_term,
    output logic                     slew_ctl_en,
    output logic [2:0]               tx_slew_clk,
    output logic [2:0]               tx_slew_data,
    output logic [3:0]               emph_lane_en,
    output rdso_pkg::rdso_emph_t     tx_emph,
    output logic [2:0]               aeq_offset
);
    import rdso_pkg::*;

    // Pin synchroniser
    localparam int PIN_W = 14;
    logic [PIN_W-1:0] pin_raw, s1_q, s2_q;
    assign pin_raw = {cfg_mode_pin, power_down_pin, coupling_select_pin, config_zero_pin,
                      lane_swap_pin, emphasis_select_pin, linear_select_pin, in_clock_lane,
                      input_data_lane_two, 2'b00};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q <= '0;
            s2_q <= '0;
        end else begin
            s1_q <= pin_raw;
            s2_q <= s1_q;
        end
    end
    logic      pd_s, cfg0_s;
    rdso_lvl_t mode_s, emph_s, lin_s;
    assign mode_s = rdso_lvl_t'(s2_q[13:12]);
    assign pd_s   = s2_q[11];
    assign cfg0_s = s2_q[9];
    assign emph_s = rdso_lvl_t'(s2_q[7:6]);
    assign lin_s  = rdso_lvl_t'(s2_q[5:4]);

    // Activity detectors, clock lane at index 0, data lane two at index 1
    rdso_lane_if lane_if [2] ();
    assign lane_if[0].lane_lvl = s2_q[3];
    assign lane_if[1].lane_lvl = s2_q[2];
    for (genvar g = 0; g < 2; g++) begin : g_det
        rdso_act_det #(.LOSS_CYC(LOSS_CYC), .WIN_CYC(WIN_CYC)) u_det (
            .pclk    (pclk),
            .presetn (presetn),
            .lane    (lane_if[g])
        );
    end

    // Strap latch, taken once after the synchroniser has filled
    logic [1:0] settle_q, settle_d;
    logic       latched_q, latched_d;
    rdso_lvl_t  mode_q, mode_d, emph_q, emph_d, lin_q, lin_d;
    logic       ac_q, ac_d, swap_q, swap_d;
    always_comb begin
        settle_d  = settle_q;
        latched_d = latched_q;
        mode_d    = mode_q;
        emph_d    = emph_q;
        lin_d     = lin_q;
        ac_d      = ac_q;
        swap_d    = swap_q;
        if (!latched_q) begin
            if (settle_q == 2'(STRAP_SETTLE - 1)) begin
                latched_d = 1'b1;
                mode_d    = mode_s;
                emph_d    = emph_s;
                lin_d     = lin_s;
                ac_d      = s2_q[10];
                swap_d    = s2_q[8];
            end else begin
                settle_d = settle_q + 2'h1;
            end
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            settle_q  <= 2'h0;
            latched_q <= 1'b0;
            mode_q    <= LVL_F;
            emph_q    <= LVL_F;
            lin_q     <= LVL_0;
            ac_q      <= 1'b0;
            swap_q    <= 1'b0;
        end else begin
            settle_q  <= settle_d;
            latched_q <= latched_d;
            mode_q    <= mode_d;
            emph_q    <= emph_d;
            lin_q     <= lin_d;
            ac_q      <= ac_d;
            swap_q    <= swap_d;
        end
    end

    // Registers
    logic [CTRL_W-1:0] ctrl_q, ctrl_d;
    logic [SLEW_W-1:0] slew_q, slew_d;
    logic [31:0]       rdata_q, rdata_d, stat_w;
    logic              ready_q, ready_d, err_q, err_d;
    logic              acc, hit;
    rdso_state_t       state_q, state_d;
    always_comb begin
        ctrl_d  = ctrl_q;
        slew_d  = slew_q;
        rdata_d = rdata_q;
        err_d   = 1'b0;
        ready_d = 1'b0;
        acc     = psel & penable & ~ready_q;
        hit     = (paddr == OFF_CTRL) | (paddr == OFF_SLEW) | (paddr == OFF_STAT);
        if (acc) begin
            ready_d = 1'b1;
            err_d   = ~hit | (pwrite & (paddr == OFF_STAT));
            rdata_d = 32'h0;
            if (pwrite) begin
                if (paddr == OFF_CTRL) ctrl_d = pwdata[CTRL_W-1:0];
                if (paddr == OFF_SLEW) slew_d = pwdata[SLEW_W-1:0];
            end else begin
                unique case (paddr)
                    OFF_CTRL: rdata_d = {{(32-CTRL_W){1'b0}}, ctrl_q};
                    OFF_SLEW: rdata_d = {{(32-SLEW_W){1'b0}}, slew_q};
                    OFF_STAT: rdata_d = stat_w;
                    default:  rdata_d = 32'h0;
                endcase
            end
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q  <= CTRL_RST;
            slew_q  <= SLEW_RST;
            rdata_q <= 32'h0;
            ready_q <= 1'b0;
            err_q   <= 1'b0;
        end else begin
            ctrl_q  <= ctrl_d;
            slew_q  <= slew_d;
            rdata_q <= rdata_d;
            ready_q <= ready_d;
            err_q   <= err_d;
        end
    end
    assign prdata  = rdata_q;
    assign pready  = ready_q;
    assign pslverr = err_q;

    // Effective configuration
    logic reg_cfg, pd, sby_en, swap, ac, limited, watch_clk, act, auto14, frl;
    logic [1:0] term_fld;
    always_comb begin
        reg_cfg   = latched_q & (mode_q == LVL_F);
        pd        = reg_cfg ? ctrl_q[CTRL_PD] : pd_s;
        sby_en    = reg_cfg ? ~ctrl_q[CTRL_SBY_DIS] : 1'b1;
        swap      = reg_cfg ? ctrl_q[CTRL_SWAP] : swap_q;
        ac        = reg_cfg ? ctrl_q[CTRL_AC] : ac_q;
        limited   = reg_cfg ? ctrl_q[CTRL_LIMITED] : (lin_q == LVL_0);
        auto14    = reg_cfg ? ctrl_q[CTRL_AUTO14] : ~cfg0_s;
        term_fld  = ctrl_q[CTRL_TERM_LSB +: 2];
        frl       = (hdmi_mode == MODE_21);
        watch_clk = ~frl ^ swap;
        act       = watch_clk ? lane_if[0].active : lane_if[1].active;
    end

    // Standby state machine
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_OFF:     state_d = ST_STANDBY;
            ST_STANDBY: if (act || !sby_en) state_d = ST_ACTIVE;
            ST_ACTIVE:  if (sby_en && !act) state_d = ST_STANDBY;
        endcase
        if (pd || !latched_q) state_d = ST_OFF;
    end

    // Clock-rate hysteresis for legacy automatic termination
    logic f_hi_q, f_hi_d;
    always_comb begin
        f_hi_d = f_hi_q;
        if (lane_if[0].edge_cnt >= 16'(F_300_EDGES)) f_hi_d = 1'b1;
        else if (lane_if[0].edge_cnt <= 16'(F_OPEN_EDGES)) f_hi_d = 1'b0;
    end

    // Output decode
    rdso_term_t term_d, auto_term;
    rdso_emph_t emph_d2;
    logic [2:0] slew_data_d, aeq_d;
    always_comb begin
        auto_term = (auto14 && !f_hi_q) ? TERM_OPEN : TERM_P300;
        if (!reg_cfg) begin
            if (ac) term_d = (hdmi_mode == MODE_14) ? TERM_S150 : TERM_S50;
            else if (hdmi_mode != MODE_14) term_d = TERM_P100;
            else term_d = cfg0_s ? TERM_P300 : auto_term;
        end else if (!ac) begin
            unique case (term_fld)
                2'b00:   term_d = TERM_OPEN;
                2'b01:   term_d = TERM_P300;
                2'b10:   term_d = (hdmi_mode == MODE_14) ? auto_term : TERM_P100;
                default: term_d = TERM_P100;
            endcase
        end else begin
            unique case (term_fld)
                2'b00, 2'b01: term_d = TERM_S150;
                2'b10:        term_d = (hdmi_mode == MODE_14) ? TERM_S150 : TERM_S50;
                default:      term_d = TERM_S50;
            endcase
        end
        unique case (hdmi_mode)
            MODE_14: slew_data_d = slew_q[SLEW_LOW_LSB +: 3];
            MODE_20: slew_data_d = slew_q[SLEW_MID_LSB +: 3];
            default: slew_data_d = (frl_rate == RATE_3G) ? slew_q[SLEW_LOW_LSB +: 3] :
                                   (frl_rate == RATE_6G) ? slew_q[SLEW_MID_LSB +: 3] :
                                   slew_q[SLEW_HIGH_LSB +: 3];
        endcase
        if (frl) emph_d2 = rdso_emph_t'({1'b1, txffe_level});
        else if (reg_cfg) emph_d2 = rdso_emph_t'({1'b0, ctrl_q[CTRL_EMPH_LSB +: 2]});
        else emph_d2 = rdso_emph_t'({1'b0, emph_q});
        aeq_d = 3'h0;
        if (!reg_cfg && (lin_q == LVL_F || lin_q == LVL_1)) begin
            unique case (emph_q)
                LVL_0:   aeq_d = 3'h1;
                LVL_R:   aeq_d = 3'h4;
                LVL_F:   aeq_d = 3'h0;
                default: aeq_d = 3'h2;
            endcase
        end
    end

    always_comb begin
        stat_w = 32'h0;
        stat_w[1:0]   = state_q;
        stat_w[2]     = signal_detect_indicator_oe;
        stat_w[3]     = act;
        stat_w[4]     = reg_cfg;
        stat_w[5]     = f_hi_q;
        stat_w[8:6]   = tx_term;
        stat_w[11:9]  = tx_emph;
        stat_w[15:12] = lane_out_en;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q                    <= ST_OFF;
            f_hi_q                     <= 1'b0;
            signal_detect_indicator_o  <= 1'b0;
            signal_detect_indicator_oe <= 1'b0;
            lane_out_en                <= 4'h0;
            tx_internal_bias           <= 1'b0;
            tx_term                    <= TERM_OPEN;
            slew_ctl_en                <= 1'b0;
            tx_slew_clk                <= 3'h0;
            tx_slew_data               <= 3'h0;
            emph_lane_en               <= 4'h0;
            tx_emph                    <= EMPH_ZERO;
            aeq_offset                 <= 3'h0;
        end else begin
            state_q                    <= state_d;
            f_hi_q                     <= f_hi_d;
            signal_detect_indicator_o  <= 1'b0;
            signal_detect_indicator_oe <= sby_en && (state_d == ST_ACTIVE);
            lane_out_en                <= (state_d == ST_ACTIVE) ? 4'hf : 4'h0;
            tx_internal_bias           <= ac;
            tx_term                    <= term_d;
            slew_ctl_en                <= reg_cfg && limited;
            tx_slew_clk                <= (reg_cfg && limited) ? slew_q[SLEW_CLK_LSB +: 3] : 3'h0;
            tx_slew_data               <= (reg_cfg && limited) ? slew_data_d : 3'h0;
            emph_lane_en               <= limited ? {frl, 3'b111} : 4'h0;
            tx_emph                    <= emph_d2;
            aeq_offset                 <= aeq_d;
        end
    end
endmodule
`default_nettype wire

/* File: rdso_video_src.sv */
// Purpose: Upstream video source toggling the clock lane and data lane two
// Assumes: Lane period 160 ns, phase unrelated to pclk
// Notes:   A lane that is not running stands still at 0
`timescale 1ns/1ps
`default_nettype none
module rdso_video_src (
    input  wire logic run_clk,
    input  wire logic run_d2,
    output logic      clk_lane,
    output logic      d2_lane
);
    initial begin
        clk_lane = 1'b0;
        d2_lane = 1'b0;
        #37;
        forever begin
            #80;
            clk_lane = run_clk ? ~clk_lane : 1'b0;
            d2_lane = run_d2 ? ~d2_lane : 1'b0;
        end
    end
endmodule
`default_nettype wire

/* File: rdso_ctrl_checker.sv */
// Purpose: Port assertions for the standby and output control block
// Assumes: Single pclk domain, async active-low reset
// Notes:   Bound into every instance of rdso_ctrl
`timescale 1ns/1ps
`default_nettype none
module rdso_ctrl_checker import rdso_pkg::*; (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [1:0]  cfg_mode_pin,
    input wire logic        power_down_pin,
    input wire logic        signal_detect_indicator_o,
    input wire logic        signal_detect_indicator_oe,
    input wire logic [3:0]  lane_out_en,
    input wire logic        slew_ctl_en,
    input wire logic [2:0]  tx_slew_clk,
    input wire logic [2:0]  tx_slew_data
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence pd_held;
        (power_down_pin && cfg_mode_pin != LVL_F) [*8];
    endsequence
    sequence strap_held;
        (cfg_mode_pin != LVL_F) [*8];
    endsequence
    pd_idle_a: assert property (pd_held |-> lane_out_en == 4'h0 && !signal_detect_indicator_oe)
        else $error("lanes on in power-down");
    ind_low_a: assert property (signal_detect_indicator_o == 1'b0)
        else $error("indicator drives high");
    ind_lanes_a: assert property (signal_detect_indicator_oe |-> lane_out_en == 4'hf)
        else $error("indicator without lanes");
    lanes_all_a: assert property (lane_out_en == 4'h0 || lane_out_en == 4'hf)
        else $error("partial lane enable");
    slew_off_a: assert property (!slew_ctl_en |-> tx_slew_clk == 3'h0 && tx_slew_data == 3'h0)
        else $error("slew set while disabled");
    strap_slew_a: assert property (strap_held |-> !slew_ctl_en)
        else $error("slew enabled in strap mode");
    rdy_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    rdy_cause_a: assert property (pready |-> $past(psel) && $past(penable))
        else $error("pready without access");
    err_data_a: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("bad error response");
    unmapped_a: assert property (psel && penable && !pready && paddr > 8'h08 |=> pslverr)
        else $error("unmapped access accepted");
endmodule
bind rdso_ctrl rdso_ctrl_checker u_chk (.pclk, .presetn, .psel, .penable, .paddr, .prdata,
    .pready, .pslverr, .cfg_mode_pin, .power_down_pin, .signal_detect_indicator_o,
    .signal_detect_indicator_oe, .lane_out_en, .slew_ctl_en, .tx_slew_clk, .tx_slew_data);
`default_nettype wire

/* File: test_redriver_standby_tx_output_ctrl.sv */
// Purpose: Self-checking bench for standby, detect indicator and output decode
// Assumes: LOSS_CYC shortened to 40; frequency window kept at full length
// Notes:   Strap and register configurations each entered by a reset
`timescale 1ns/1ps
`default_nettype none
module test_redriver_standby_tx_output_ctrl;
    import rdso_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, power_down_pin;
    logic        coupling_select_pin, config_zero_pin, lane_swap_pin, in_clock_lane;
    logic        input_data_lane_two, signal_detect_indicator_o, signal_detect_indicator_oe;
    logic        tx_internal_bias, slew_ctl_en, run_clk, run_d2;
    logic [1:0]  cfg_mode_pin, emphasis_select_pin, linear_select_pin, txffe_level;
    logic [2:0]  tx_slew_clk, tx_slew_data, aeq_offset;
    logic [3:0]  lane_out_en, emph_lane_en;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    rdso_mode_t  hdmi_mode;
    rdso_rate_t  frl_rate;
    rdso_term_t  tx_term;
    rdso_emph_t  tx_emph;
    int          err_count, total_checks;
    rdso_term_t  tt [8] = '{TERM_OPEN, TERM_P300, TERM_P100, TERM_P100,
                            TERM_S150, TERM_S150, TERM_S150, TERM_S50};
    always #2.5 pclk = ~pclk;
    rdso_ctrl #(.LOSS_CYC(40)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .cfg_mode_pin, .power_down_pin, .coupling_select_pin,
        .config_zero_pin, .lane_swap_pin, .emphasis_select_pin, .linear_select_pin,
        .in_clock_lane, .input_data_lane_two, .hdmi_mode, .frl_rate, .txffe_level,
        .signal_detect_indicator_o, .signal_detect_indicator_oe, .lane_out_en,
        .tx_internal_bias, .tx_term, .slew_ctl_en, .tx_slew_clk, .tx_slew_data,
        .emph_lane_en, .tx_emph, .aeq_offset);
    rdso_video_src src (.run_clk, .run_d2, .clk_lane(in_clock_lane),
        .d2_lane(input_data_lane_two));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic er);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        rd = prdata;
        chk("pready_pslverr", {30'h0, 1'b1, er}, {30'h0, pready, pslverr});
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wt(input int c);
        repeat (c) @(posedge pclk);
    endtask
    task automatic wl(input logic [3:0] e);
        int n;
        n = 0;
        while (lane_out_en !== e && n < 400) begin
            @(posedge pclk);
            n++;
        end
        chk("lane_out_en", e, lane_out_en);
    endtask
    task automatic rst(input logic [1:0] m, input logic c, input logic s,
                       input logic [1:0] e, input logic [1:0] l);
        @(posedge pclk);
        presetn <= 1'b0;
        cfg_mode_pin <= m;
        coupling_select_pin <= c;
        lane_swap_pin <= s;
        emphasis_select_pin <= e;
        linear_select_pin <= l;
        wt(3);
        presetn <= 1'b1;
        wt(12);
    endtask
    task test_done;
        $display("Checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        #200000;
        err_count++;
        test_done;
    end
    initial begin
        {pclk, presetn, psel, penable, pwrite, power_down_pin, config_zero_pin} = 7'h0;
        {run_clk, run_d2, paddr, pwdata, txffe_level} = '0;
        hdmi_mode = MODE_14;
        frl_rate = RATE_3G;
        rst(LVL_0, 1'b0, 1'b0, LVL_R, LVL_0);
        chk("lanes_reset", 4'h0, lane_out_en);
        chk("bias_dc", 1'b0, tx_internal_bias);
        chk("aeq_lin0", 3'h0, aeq_offset);
        run_d2 <= 1'b1;
        wt(200);
        chk("lanes_d2_legacy", 4'h0, lane_out_en);
        run_clk <= 1'b1;
        wl(4'hf);
        chk("ind_on", 1'b1, signal_detect_indicator_oe);
        chk("emph_pin_r", EMPH_DE25, tx_emph);
        chk("emph_lanes", 4'h7, emph_lane_en);
        wt(2200);
        chk("term_fast", TERM_P300, tx_term);
        run_clk <= 1'b0;
        run_d2 <= 1'b0;
        wl(4'h0);
        chk("ind_off", 1'b0, signal_detect_indicator_oe);
        wt(2100);
        chk("term_slow", TERM_OPEN, tx_term);
        config_zero_pin <= 1'b1;
        wt(6);
        chk("term_cfg0", TERM_P300, tx_term);
        config_zero_pin <= 1'b0;
        hdmi_mode <= MODE_21;
        run_clk <= 1'b1;
        wt(200);
        chk("lanes_clk_frl", 4'h0, lane_out_en);
        run_d2 <= 1'b1;
        wl(4'hf);
        chk("emph_lanes_frl", 4'hf, emph_lane_en);
        chk("term_frl_dc", TERM_P100, tx_term);
        chk("emph_frl", EMPH_FFE0, tx_emph);
        {run_clk, run_d2} <= 2'b00;
        hdmi_mode <= MODE_14;
        rst(LVL_0, 1'b1, 1'b1, LVL_1, LVL_F);
        coupling_select_pin <= 1'b0;
        wt(8);
        chk("bias_latched", 1'b1, tx_internal_bias);
        chk("term_ac14", TERM_S150, tx_term);
        chk("aeq_pin1", 3'h2, aeq_offset);
        chk("emph_linear", 4'h0, emph_lane_en);
        run_d2 <= 1'b1;
        wl(4'hf);
        power_down_pin <= 1'b1;
        wl(4'h0);
        chk("ind_pd", 1'b0, signal_detect_indicator_oe);
        {power_down_pin, run_d2} <= 2'b00;
        rst(LVL_F, 1'b0, 1'b0, LVL_0, LVL_0);
        apb(1'b0, OFF_CTRL, 32'h0, 1'b0);
        chk("ctrl_reset", 32'(CTRL_RST), rd);
        apb(1'b0, OFF_SLEW, 32'h0, 1'b0);
        chk("slew_reset", 32'(SLEW_RST), rd);
        apb(1'b0, 8'h0c, 32'h0, 1'b1);
        apb(1'b1, OFF_STAT, 32'h5, 1'b1);
        chk("lanes_reg_pd", 4'h0, lane_out_en);
        apb(1'b1, OFF_CTRL, 32'h2, 1'b0);
        wl(4'hf);
        chk("ind_sby_dis", 1'b0, signal_detect_indicator_oe);
        for (int i = 0; i < 8; i++) begin
            hdmi_mode <= i[2] ? MODE_14 : MODE_20;
            apb(1'b1, OFF_CTRL, 32'h42 | (i & 4) | ((i & 3) << 4), 1'b0);
            wt(6);
            chk("term_reg", tt[i], tx_term);
            chk("bias_reg", i[2], tx_internal_bias);
        end
        apb(1'b1, OFF_SLEW, 32'h13, 1'b0);
        wt(6);
        chk("slew_en", 1'b1, slew_ctl_en);
        chk("slew_clk", 3'h3, tx_slew_clk);
        chk("slew_data", 3'h2, tx_slew_data);
        apb(1'b1, OFF_CTRL, 32'h2, 1'b0);
        wt(6);
        chk("slew_linear", 1'b0, slew_ctl_en);
        chk("emph_reg_lin", 4'h0, emph_lane_en);
        test_done;
    end
endmodule
`default_nettype wire
